/* File: dv/stx_monitor.sv */
// Assertions on the wires between the two ends
`timescale 1ns/1ps
module stx_monitor import stx_pkg::*; #(
  parameter int DIV = STX_DIV_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic gio0_host_o,
  input wire logic gio0_dev_oe,
  input wire logic bit_clk,
  input wire logic [1:0] packet_format_select,
  input wire logic tx_active,
  input wire logic mod_valid,
  input wire logic mod_from_pkt,
  input wire logic sync_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] hi_q;
  logic [15:0] hi_d;
  // Counter, since high time is too long to repeat
  assign hi_d = bit_clk ? hi_q + 16'h1 : 16'h0;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      hi_q <= 16'h0;
    end else begin
      hi_q <= hi_d;
    end
  end
  chk_sync_entry: assert property (
    $rose(tx_active) && packet_format_select == STX_FMT_SYNC
    |-> ##[1:2] sync_mode) else $error("sync mode not entered");
  chk_pin_input: assert property (
    (sync_mode && tx_active)[*2] |-> !gio0_dev_oe)
    else $error("pin zero driven during sync transmit");
  chk_async_nopkt: assert property (
    mod_valid && packet_format_select == STX_FMT_ASYNC |-> !mod_from_pkt)
    else $error("packet features used in async mode");
  chk_valid_pulse: assert property (
    mod_valid |=> !mod_valid) else $error("valid longer than one cycle");
  chk_clk_high: assert property (
    $fell(bit_clk) |-> hi_q == 4 * DIV) else $error("bit clock high time");
  chk_rise_sample: assert property (
    $rose(bit_clk) && sync_mode |-> mod_valid)
    else $error("no sample after clock rise");
  chk_host_update: assert property (
    sync_mode && tx_active && !$stable(gio0_host_o) |-> !bit_clk)
    else $error("host data moved while clock high");
  chk_stable_rise: assert property (
    $rose(bit_clk) && sync_mode |-> $stable(gio0_host_o))
    else $error("host data moved at sampling edge");
endmodule // stx_monitor

/* File: dv/tb_top.sv */
// Self-checking bench joining device and host ends
`timescale 1ns/1ps
module tb_top import stx_pkg::*; ();
  localparam int DV = 2;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] fmt = STX_FMT_FIFO;
  logic ins = 1'b0;
  logic act = 1'b0;
  logic in_bit = 1'b0;
  logic in_valid = 1'b0;
  logic in_ready, mod_bit, mod_valid, mod_from_pkt, sync_mode, urun;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  stx_if u_stx_if();
  stx_dev #(.DIV(DV)) u_stx_dev(.core_clk(core_clk), .rst_b(rst_b),
    .pins(u_stx_if.dev), .packet_format_select(fmt),
    .sync_insert_en(ins), .tx_active(act), .mod_bit(mod_bit),
    .mod_valid(mod_valid), .mod_from_pkt(mod_from_pkt),
    .sync_mode(sync_mode));
  stx_host #(.DIV(DV)) u_stx_host(.core_clk(core_clk), .rst_b(rst_b),
    .pins(u_stx_if.host), .sync_mode(sync_mode), .in_bit(in_bit),
    .in_valid(in_valid), .in_ready(in_ready), .underrun(urun));
  stx_monitor #(.DIV(DV)) u_stx_monitor(.core_clk(core_clk),
    .rst_b(rst_b), .gio0_host_o(u_stx_if.gio0_host_o),
    .gio0_dev_oe(u_stx_if.gio0_dev_oe), .bit_clk(u_stx_if.bit_clk),
    .packet_format_select(fmt), .tx_active(act), .mod_valid(mod_valid),
    .mod_from_pkt(mod_from_pkt), .sync_mode(sync_mode));
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic restart(logic [1:0] f, logic i);
    rst_b <= 1'b0;
    act <= 1'b0;
    fmt <= f;
    ins <= i;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  // Valid held across bits, so no re-raise at one edge
  task automatic push(logic [31:0] w, int n);
    for (int k = n - 1; k >= 0; k--) begin
      in_bit <= w[k];
      in_valid <= 1'b1;
      @(posedge core_clk);
      while (in_ready !== 1'b1) @(posedge core_clk);
    end
    in_valid <= 1'b0;
  endtask
  task automatic grab(int n, output logic [63:0] v);
    v = '0;
    repeat (n) begin
      @(posedge core_clk);
      while (mod_valid !== 1'b1) @(posedge core_clk);
      v = {v[62:0], mod_bit};
    end
  endtask
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    logic [63:0] v;
    int k;
    restart(STX_FMT_SYNC, 1'b1);
    chk("idle oe", 1, u_stx_if.gio0_dev_oe);
    // One bit waits on the pin, so 17 fill the queue
    push(32'h18B47, 17);
    @(posedge core_clk);
    chk("full ready", 0, in_ready);
    act <= 1'b1;
    grab(48, v);
    chk("header", {STX_PREAMBLE, STX_SYNC_WORD}, v);
    grab(16, v);
    chk("ins payload", 64'hC5A3, v);
    chk("sync mode", 1, sync_mode);
    chk("tx oe", 0, u_stx_if.gio0_dev_oe);
    restart(STX_FMT_SYNC, 1'b0);
    push(32'h5A3C, 16);
    act <= 1'b1;
    grab(16, v);
    chk("payload", 64'h5A3C, v);
    repeat (4) @(posedge core_clk);
    chk("drained ready", 1, in_ready);
    k = 0;
    while (urun !== 1'b1 && k < 40) begin
      @(posedge core_clk);
      k++;
    end
    chk("underrun", 1, urun);
    restart(STX_FMT_ASYNC, 1'b0);
    act <= 1'b1;
    push(32'hFF00, 16);
    repeat (40) @(posedge core_clk);
    chk("async high", 1, mod_bit);
    chk("async pkt", 0, mod_from_pkt);
    chk("async mode", 0, sync_mode);
    chk("async oe", 0, u_stx_if.gio0_dev_oe);
    repeat (160) @(posedge core_clk);
    chk("async low", 0, mod_bit);
    end_of_test();
  end
endmodule // tb_top

/* File: logic/stx_dev.sv */
// Device end: serial transmit data input of the modulator
`timescale 1ns/1ps
module stx_dev import stx_pkg::*; #(
  parameter int DIV = STX_DIV_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  stx_if.dev pins,
  input wire logic [1:0] packet_format_select,
  input wire logic sync_insert_en,
  input wire logic tx_active,
  output logic mod_bit,
  output logic mod_valid,
  output logic mod_from_pkt,
  output logic sync_mode
);
  logic [2:0] s_q;
  logic [15:0] div_q;
  logic [2:0] ph_q;
  logic bclk_q, oe_q, dout_q;
  logic bit_q, val_q, pkt_q, sm_q;
  stx_state_t st_q;
  logic [5:0] hcnt_q;
  wire is_async = packet_format_select == STX_FMT_ASYNC;
  wire is_sync = packet_format_select == STX_FMT_SYNC;
  wire tick = div_q == 16'(DIV - 1);
  wire pin_in = s_q[2]; // Stable once 2nd and 3rd stage agree
  wire agree = s_q[1] == s_q[2];
  wire rise = tick && ph_q == 3'h7; // Bit clock rising edge
  wire fall = tick && ph_q == STX_MID_SAMPLE - 3'h1;
  wire [47:0] head = {STX_PREAMBLE, STX_SYNC_WORD};
  wire run = tx_active && (is_sync || is_async);
  assign pins.bit_clk = bclk_q;
  assign pins.gio0_dev_oe = oe_q;
  assign pins.gio0_dev_o = dout_q;
  assign mod_bit = bit_q;
  assign mod_valid = val_q;
  assign mod_from_pkt = pkt_q;
  assign sync_mode = sm_q;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= {s_q[1:0], pins.gio0};
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b || !run) begin
      div_q <= '0;
      ph_q <= '0;
    end else if (tick) begin
      div_q <= '0;
      ph_q <= ph_q + 3'h1;
    end else begin
      div_q <= div_q + 16'h1;
    end
  end
  // Pin released to input in either serial mode while sending
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      oe_q <= 1'b0;
      dout_q <= 1'b0;
      sm_q <= 1'b0;
    end else begin
      oe_q <= !(tx_active && (is_sync || is_async));
      dout_q <= 1'b0;
      sm_q <= is_sync;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bclk_q <= 1'b0;
    end else if (!(tx_active && is_sync) || st_q != STX_DATA) begin
      bclk_q <= 1'b0; // Low through header, payload only
    end else if (rise) begin
      bclk_q <= 1'b1;
    end else if (fall) begin
      bclk_q <= 1'b0;
    end
  end
  // Header before payload only when insertion is on
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= STX_IDLE;
      hcnt_q <= '0;
      bit_q <= 1'b0;
      val_q <= 1'b0;
      pkt_q <= 1'b0;
    end else begin
      val_q <= 1'b0;
      unique case (st_q)
        STX_IDLE: begin
          pkt_q <= 1'b0;
          hcnt_q <= '0;
          if (tx_active && is_sync) begin
            st_q <= sync_insert_en ? STX_HEAD : STX_DATA;
          end else if (tx_active && is_async && tick && agree) begin
            bit_q <= pin_in; // Raw, no coding
            val_q <= 1'b1;
          end
        end
        STX_HEAD: begin
          if (!tx_active || !is_sync) begin
            st_q <= STX_IDLE;
          end else if (rise) begin
            bit_q <= head[6'd47 - hcnt_q];
            val_q <= 1'b1;
            hcnt_q <= hcnt_q + 6'h1;
            if (hcnt_q == 6'd47) st_q <= STX_DATA;
          end
        end
        STX_DATA: begin
          pkt_q <= sync_insert_en; // Packet features may follow
          if (!tx_active || !is_sync) begin
            st_q <= STX_IDLE;
          end else if (rise) begin
            bit_q <= pin_in;
            val_q <= 1'b1;
          end
        end
        default: st_q <= STX_IDLE;
      endcase
    end
  end
endmodule // stx_dev

/* File: logic/stx_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module stx_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // stx_fifo

/* File: logic/stx_host.sv */
// Host end: feeds transmit bits onto pin zero
`timescale 1ns/1ps
module stx_host import stx_pkg::*; #(
  parameter int DIV = STX_DIV_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  stx_if.host pins,
  input wire logic sync_mode,
  input wire logic in_bit,
  input wire logic in_valid,
  output logic in_ready,
  output logic underrun
);
  logic [2:0] c_q;
  logic [15:0] div_q;
  logic [2:0] ph_q;
  logic o_q, oe_q, ur_q, lvl_q, have_q;
  logic fbit;
  logic fval;
  // Edge counts once the second and third stages agree
  wire agree = c_q[1] == c_q[2];
  wire cfall = agree && lvl_q && !c_q[2];
  // First bit must stand on the pin before the first rise
  wire load = sync_mode && !have_q && fval;
  wire btick = div_q == 16'(DIV - 1) && ph_q == 3'h7;
  wire adv = sync_mode ? (cfall || load) : btick;
  stx_fifo #(.WIDTH(1), .DEPTH(STX_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_data(in_bit),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(fbit),
    .out_valid(fval),
    .out_ready(adv)
  );
  assign pins.gio0_host_o = o_q;
  assign pins.gio0_host_oe = oe_q;
  assign underrun = ur_q;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      c_q <= '0;
      lvl_q <= 1'b0;
    end else begin
      c_q <= {c_q[1:0], pins.bit_clk};
      if (agree) lvl_q <= c_q[2];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b || sync_mode) begin
      div_q <= '0;
      ph_q <= '0;
    end else if (div_q == 16'(DIV - 1)) begin
      div_q <= '0;
      ph_q <= ph_q + 3'h1;
    end else begin
      div_q <= div_q + 16'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      o_q <= 1'b0;
      oe_q <= 1'b0;
      ur_q <= 1'b0;
      have_q <= 1'b0;
    end else begin
      oe_q <= 1'b1;
      ur_q <= adv && !fval;
      if (!sync_mode) begin
        have_q <= 1'b0;
      end else if (load) begin
        have_q <= 1'b1;
      end else if (cfall && !fval) begin
        have_q <= 1'b0;
      end
      if (adv && fval) o_q <= fbit;
    end
  end
endmodule // stx_host

/* File: logic/stx_if.sv */
// Pin interface between radio device and host
`timescale 1ns/1ps
interface stx_if;
  logic gio0_host_o;
  logic gio0_host_oe;
  logic gio0_dev_o;
  logic gio0_dev_oe;
  logic bit_clk;
  logic gio0;
  // Undriven pin shows the inverse of the last host level
  assign gio0 = gio0_dev_oe ? gio0_dev_o :
    (gio0_host_oe ? gio0_host_o : !gio0_host_o);
  modport dev (input gio0, output gio0_dev_o, output gio0_dev_oe,
    output bit_clk);
  modport host (input gio0, input bit_clk, output gio0_host_o,
    output gio0_host_oe);
endinterface

/* File: logic/stx_pkg.sv */
// Package for the serial transmit data input path
// What this block does
// - Format value three selects asynchronous serial mode
// - Async mode bypasses packet logic and FIFO
// - Async mode applies no whitening, FEC, Manchester
// - Host never pairs MSK with async mode
// - Async data comes from general I/O pin zero
// - Async input sampled at eight times rate
// - Host bit period error below one eighth
// - Format value one selects synchronous serial mode
// - Device drives bit clock; host follows it
// - Pin zero becomes input during sync transmit
// - Preamble and sync inserted only when enabled
// - Without insertion host sends its own preamble
// - With insertion host supplies only payload bits
package stx_pkg;
  localparam logic [1:0] STX_FMT_FIFO = 2'h0;
  localparam logic [1:0] STX_FMT_SYNC = 2'h1;
  localparam logic [1:0] STX_FMT_ASYNC = 2'h3;
  localparam int STX_OVERSAMPLE = 8;
  localparam int STX_CLK_HZ = 10000000;
  localparam int STX_RATE_DEF = 100000;
  localparam int STX_DIV_DEF = STX_CLK_HZ / STX_RATE_DEF / STX_OVERSAMPLE;
  localparam int STX_PRE_BITS = 32;
  localparam logic [31:0] STX_PREAMBLE = 32'hAAAAAAAA;
  localparam logic [15:0] STX_SYNC_WORD = 16'hD391;
  localparam int STX_FIFO_DEPTH = 16;
  localparam logic [2:0] STX_MID_SAMPLE = 3'h4;
  typedef enum logic [1:0] {
    STX_IDLE = 2'h0,
    STX_HEAD = 2'h1,
    STX_DATA = 2'h3
  } stx_state_t;
endpackage
